/* File: include/lcr_pkg.sv */
`default_nettype none

package lcr_pkg;

    // Register offsets on the management bus.
    localparam logic [7:0] OFS_EQ        = 8'h2C;
    localparam logic [7:0] OFS_SWING     = 8'h2D;
    localparam logic [7:0] OFS_DEEMPH    = 8'h2E;
    localparam logic [7:0] OFS_IDLE_THR  = 8'h2F;
    localparam logic [7:0] OFS_IDLE_RATE = 8'h32;

    // Reset values.
    localparam logic [7:0] RST_EQ        = 8'h20;
    localparam logic [7:0] RST_SWING     = 8'h03;
    localparam logic [7:0] RST_DEEMPH    = 8'h03;
    localparam logic [7:0] RST_IDLE_THR  = 8'h00;
    localparam logic [7:0] RST_IDLE_RATE = 8'h00;
    localparam logic [7:0] RD_UNMAPPED   = 8'h00;

    // Writable bits; reserved bits are not stored and read as zero.
    localparam logic [7:0] MASK_EQ        = 8'h3F;
    localparam logic [7:0] MASK_SWING     = 8'h7F;
    localparam logic [7:0] MASK_DEEMPH    = 8'hFF;
    localparam logic [7:0] MASK_IDLE_THR  = 8'h0F;
    localparam logic [7:0] MASK_IDLE_RATE = 8'h33;

    // Field positions.
    localparam int EQ_EN_BIT       = 5;
    localparam int EQ_GAIN_MSB     = 4;
    localparam int EQ_GAIN_LSB     = 3;
    localparam int EQ_BOOST_MSB    = 2;
    localparam int DEEMPH_TYPE_BIT = 7;
    localparam int DEEMPH_LVL_MSB  = 6;
    localparam int THR_DEASSERT_MSB = 3;
    localparam int THR_DEASSERT_LSB = 2;
    localparam int THR_ASSERT_MSB  = 1;
    localparam int IDLE_AUTO_BIT   = 5;
    localparam int IDLE_SEL_BIT    = 4;
    localparam int RATE_AUTO_BIT   = 1;
    localparam int RATE_SEL_BIT    = 0;

    // Output swing codes and their levels in mV.
    localparam logic [6:0]  SWING_C600  = 7'h03;
    localparam logic [6:0]  SWING_C800  = 7'h07;
    localparam logic [6:0]  SWING_C1000 = 7'h0F;
    localparam logic [6:0]  SWING_C1200 = 7'h1F;
    localparam logic [6:0]  SWING_C1400 = 7'h3F;
    localparam logic [10:0] SWING_MV600  = 11'd600;
    localparam logic [10:0] SWING_MV800  = 11'd800;
    localparam logic [10:0] SWING_MV1000 = 11'd1000;
    localparam logic [10:0] SWING_MV1200 = 11'd1200;
    localparam logic [10:0] SWING_MV1400 = 11'd1400;
    localparam logic [10:0] SWING_MV_NONE = 11'd0;

    // De-emphasis codes.
    localparam logic [7:0] DEEMPH_0DB      = 8'h01;
    localparam logic [7:0] DEEMPH_M6DB     = 8'h88;
    localparam logic [7:0] DEEMPH_M9DB     = 8'h90;
    localparam logic [7:0] DEEMPH_M12DB    = 8'hA0;
    localparam logic [7:0] DEEMPH_RESERVED = 8'hC0;

    // Idle thresholds in mV, de-assert then assert, per 2-bit code.
    localparam logic [7:0] THR_DEASSERT_MV0 = 8'd110;
    localparam logic [7:0] THR_DEASSERT_MV1 = 8'd150;
    localparam logic [7:0] THR_DEASSERT_MV2 = 8'd170;
    localparam logic [7:0] THR_DEASSERT_MV3 = 8'd190;
    localparam logic [7:0] THR_ASSERT_MV0   = 8'd70;
    localparam logic [7:0] THR_ASSERT_MV1   = 8'd110;
    localparam logic [7:0] THR_ASSERT_MV2   = 8'd130;
    localparam logic [7:0] THR_ASSERT_MV3   = 8'd150;

    // Three-level equalizer pin states and the register code of each pair.
    localparam logic [1:0] PIN_LOW   = 2'h0;
    localparam logic [1:0] PIN_HIGH  = 2'h1;
    localparam logic [1:0] PIN_FLOAT = 2'h2;
    localparam logic [5:0] EQPIN_FF = 6'h20;
    localparam logic [5:0] EQPIN_11 = 6'h2A;
    localparam logic [5:0] EQPIN_00 = 6'h30;
    localparam logic [5:0] EQPIN_F0 = 6'h32;
    localparam logic [5:0] EQPIN_10 = 6'h39;
    localparam logic [5:0] EQPIN_F1 = 6'h35;
    localparam logic [5:0] EQPIN_01 = 6'h35;
    localparam logic [5:0] EQPIN_0F = 6'h3B;
    localparam logic [5:0] EQPIN_1F = 6'h3D;

    // Pin synchroniser layout and idle levels.
    localparam int         SYNC_W       = 8;
    localparam int         SYNC_SCL     = 7;
    localparam int         SYNC_SDA     = 6;
    localparam int         SYNC_EQH_MSB = 5;
    localparam int         SYNC_EQH_LSB = 4;
    localparam int         SYNC_EQL_MSB = 3;
    localparam int         SYNC_EQL_LSB = 2;
    localparam int         SYNC_IDLE    = 1;
    localparam int         SYNC_RATE    = 0;
    localparam logic [7:0] SYNC_RST     = 8'hC0;

    // Management bus framing.
    localparam logic [3:0] BYTE_BITS        = 4'h8;
    localparam logic [3:0] BIT_FIRST        = 4'h1;
    localparam logic [6:0] SMB_ADDR_DEFAULT = 7'h2A;

    typedef enum logic [3:0] {
        ST_IDLE      = 4'h0,
        ST_ADDR      = 4'h1,
        ST_ADDR_ACK  = 4'h2,
        ST_CMD       = 4'h3,
        ST_CMD_ACK   = 4'h4,
        ST_WDATA     = 4'h5,
        ST_WDATA_ACK = 4'h6,
        ST_RDATA     = 4'h7,
        ST_RDATA_ACK = 4'h8
    } lcr_state_e;

    typedef struct packed {
        logic [7:0] eq;
        logic [7:0] swing;
        logic [7:0] deemph;
        logic [7:0] idleThr;
        logic [7:0] idleRate;
    } lcr_regs_s;

    typedef struct packed {
        logic        eqEnable;
        logic [1:0]  gainStage;
        logic [2:0]  boostLevel;
        logic [6:0]  swingCode;
        logic [10:0] swingMv;
        logic        deemphEnhanced;
        logic [6:0]  deemphLevel;
        logic [7:0]  deassertMv;
        logic [7:0]  assertMv;
        logic        outputMute;
        logic        signalDetectEnable;
        logic        rateGen2;
        logic [5:0]  pinEqCode;
    } lcr_cond_s;

endpackage : lcr_pkg

`default_nettype wire

/* File: rtl/lcr_lane_decode.sv */
`timescale 1ns/10ps
`default_nettype none

module lcr_lane_decode (
    // Clock and reset.
    input  wire logic               mclk,
    input  wire logic               rst_n,
    // Register contents and synchronised pins.
    input  wire lcr_pkg::lcr_regs_s regs,
    input  wire logic [1:0]         eqPinHigh,
    input  wire logic [1:0]         eqPinLow,
    input  wire logic               idleDetected,
    input  wire logic               rateDetectedGen2,
    // Conditioning settings.
    output var  lcr_pkg::lcr_cond_s cond
);

    lcr_pkg::lcr_cond_s next_cond;

    always_comb begin
        next_cond = cond;
        // R1 - equalizer field split.
        next_cond.eqEnable   = regs.eq[lcr_pkg::EQ_EN_BIT];
        next_cond.gainStage  = regs.eq[lcr_pkg::EQ_GAIN_MSB:lcr_pkg::EQ_GAIN_LSB];
        next_cond.boostLevel = regs.eq[lcr_pkg::EQ_BOOST_MSB:0];
        // R4 - swing code to level.
        next_cond.swingCode = regs.swing[6:0];
        case (regs.swing[6:0])
            lcr_pkg::SWING_C600:  next_cond.swingMv = lcr_pkg::SWING_MV600;
            lcr_pkg::SWING_C800:  next_cond.swingMv = lcr_pkg::SWING_MV800;
            lcr_pkg::SWING_C1000: next_cond.swingMv = lcr_pkg::SWING_MV1000;
            lcr_pkg::SWING_C1200: next_cond.swingMv = lcr_pkg::SWING_MV1200;
            lcr_pkg::SWING_C1400: next_cond.swingMv = lcr_pkg::SWING_MV1400;
            default:              next_cond.swingMv = lcr_pkg::SWING_MV_NONE;
        endcase
        // R6 - reserved code falls back to 0 dB so the driver never sees it.
        if (regs.deemph == lcr_pkg::DEEMPH_RESERVED) begin
            next_cond.deemphEnhanced = lcr_pkg::DEEMPH_0DB[lcr_pkg::DEEMPH_TYPE_BIT];
            next_cond.deemphLevel    = lcr_pkg::DEEMPH_0DB[lcr_pkg::DEEMPH_LVL_MSB:0];
        end else begin
            // R5 - type bit selects enhanced mode.
            next_cond.deemphEnhanced = regs.deemph[lcr_pkg::DEEMPH_TYPE_BIT];
            next_cond.deemphLevel    = regs.deemph[lcr_pkg::DEEMPH_LVL_MSB:0];
        end
        // R7 R8 - de-assert and assert thresholds.
        case (regs.idleThr[lcr_pkg::THR_DEASSERT_MSB:lcr_pkg::THR_DEASSERT_LSB])
            2'h0:    next_cond.deassertMv = lcr_pkg::THR_DEASSERT_MV0;
            2'h1:    next_cond.deassertMv = lcr_pkg::THR_DEASSERT_MV1;
            2'h2:    next_cond.deassertMv = lcr_pkg::THR_DEASSERT_MV2;
            default: next_cond.deassertMv = lcr_pkg::THR_DEASSERT_MV3;
        endcase
        case (regs.idleThr[lcr_pkg::THR_ASSERT_MSB:0])
            2'h0:    next_cond.assertMv = lcr_pkg::THR_ASSERT_MV0;
            2'h1:    next_cond.assertMv = lcr_pkg::THR_ASSERT_MV1;
            2'h2:    next_cond.assertMv = lcr_pkg::THR_ASSERT_MV2;
            default: next_cond.assertMv = lcr_pkg::THR_ASSERT_MV3;
        endcase
        // R9 R10 - automatic or manual idle muting.
        if (regs.idleRate[lcr_pkg::IDLE_AUTO_BIT]) begin
            next_cond.outputMute         = idleDetected;
            next_cond.signalDetectEnable = 1'b1;
        end else begin
            next_cond.outputMute         = regs.idleRate[lcr_pkg::IDLE_SEL_BIT];
            next_cond.signalDetectEnable = 1'b0;
        end
        // R11 - automatic or forced rate.
        if (regs.idleRate[lcr_pkg::RATE_AUTO_BIT]) begin
            next_cond.rateGen2 = rateDetectedGen2;
        end else begin
            next_cond.rateGen2 = regs.idleRate[lcr_pkg::RATE_SEL_BIT];
        end
        // R3 - pin pair to register encoding.
        case ({eqPinHigh, eqPinLow})
            {lcr_pkg::PIN_HIGH, lcr_pkg::PIN_HIGH}:   next_cond.pinEqCode = lcr_pkg::EQPIN_11;
            {lcr_pkg::PIN_LOW, lcr_pkg::PIN_LOW}:     next_cond.pinEqCode = lcr_pkg::EQPIN_00;
            {lcr_pkg::PIN_FLOAT, lcr_pkg::PIN_LOW}:   next_cond.pinEqCode = lcr_pkg::EQPIN_F0;
            {lcr_pkg::PIN_HIGH, lcr_pkg::PIN_LOW}:    next_cond.pinEqCode = lcr_pkg::EQPIN_10;
            {lcr_pkg::PIN_FLOAT, lcr_pkg::PIN_HIGH}:  next_cond.pinEqCode = lcr_pkg::EQPIN_F1;
            {lcr_pkg::PIN_LOW, lcr_pkg::PIN_HIGH}:    next_cond.pinEqCode = lcr_pkg::EQPIN_01;
            {lcr_pkg::PIN_LOW, lcr_pkg::PIN_FLOAT}:   next_cond.pinEqCode = lcr_pkg::EQPIN_0F;
            {lcr_pkg::PIN_HIGH, lcr_pkg::PIN_FLOAT}:  next_cond.pinEqCode = lcr_pkg::EQPIN_1F;
            default:                                  next_cond.pinEqCode = lcr_pkg::EQPIN_FF;
        endcase
    end

    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            cond <= '0;
        end else begin
            cond <= next_cond;
        end
    end

endmodule : lcr_lane_decode

`default_nettype wire

/* File: rtl/lcr_lane_regs.sv */
//Contract
// R1 - The equalizer field splits into enable at bit 5, gain stage at bits 4:3, boost at 2:0.
// R2 - After reset the equalizer register holds the bypass value 20 hex.
// R3 - Each equalizer pin pair maps to a fixed register code such as 11 to 2A hex.
// R4 - The seven-bit swing code selects 600 to 1400 mV, with 03 hex at reset.
// R5 - De-emphasis bit 7 selects compatibility mode at zero and enhanced mode at one.
// R6 - De-emphasis codes 01, 88, 90 and A0 hex give 0, -6, -9 and -12 dB; C0 is reserved.
// R7 - Idle threshold bits 3:2 set the de-assert level and bits 1:0 the assert level.
// R8 - Threshold codes 00 to 11 map to 110/70, 150/110, 170/130 and 190/150 mV.
// R9 - With idle-auto set, muting follows idle detection, else the idle select bit decides.
// R10 - Under manual idle, select zero keeps the output on, one mutes it.
// R11 - With rate-auto set the rate is detected, else bit 0 forces 2.5 or 5.0 Gbps.
// R12 - The host writes zero to reserved bits and ignores their read value.
`timescale 1ns/10ps
`default_nettype none

module lcr_lane_regs #(
    parameter logic [6:0] SLAVE_ADDR = lcr_pkg::SMB_ADDR_DEFAULT
) (
    // Clock and reset.
    input  wire logic               mclk,
    input  wire logic               rst_n,
    // Management bus pins, open drain.
    input  wire logic               smbClk,
    input  wire logic               smbDataIn,
    output var  logic               smbDataOut,
    output var  logic               smbDataOe,
    // Equalizer strap pins, three-level codes.
    input  wire logic [1:0]         equalizerPinHigh,
    input  wire logic [1:0]         equalizerPinLow,
    // Analog detector status.
    input  wire logic               idleDetect,
    input  wire logic               rateDetect,
    // Conditioning settings to the analog lane.
    output var  lcr_pkg::lcr_cond_s cond
);

    logic [lcr_pkg::SYNC_W-1:0] pinMeta;
    logic [lcr_pkg::SYNC_W-1:0] pinSync;
    logic [lcr_pkg::SYNC_W-1:0] next_pinMeta;
    logic [lcr_pkg::SYNC_W-1:0] next_pinSync;
    logic                       sclPrev;
    logic                       sdaPrev;
    logic                       next_sclPrev;
    logic                       next_sdaPrev;
    logic                       sclBit;
    logic                       sdaBit;
    logic                       sclRise;
    logic                       sclFall;
    logic                       startSeen;
    logic                       stopSeen;

    lcr_pkg::lcr_state_e        state;
    lcr_pkg::lcr_state_e        next_state;
    logic [3:0]                 bitCnt;
    logic [3:0]                 next_bitCnt;
    logic [7:0]                 shiftReg;
    logic [7:0]                 next_shiftReg;
    logic                       readMode;
    logic                       next_readMode;
    logic [7:0]                 pointer;
    logic [7:0]                 next_pointer;
    logic                       sdaOe;
    logic                       next_sdaOe;
    logic [7:0]                 readData;

    lcr_pkg::lcr_regs_s         regs;
    lcr_pkg::lcr_regs_s         next_regs;

    // Pins are asynchronous to mclk; edges are only judged on the second stage.
    always_comb begin
        next_pinMeta = {smbClk, smbDataIn, equalizerPinHigh, equalizerPinLow,
                        idleDetect, rateDetect};
        next_pinSync = pinMeta;
        next_sclPrev = pinSync[lcr_pkg::SYNC_SCL];
        next_sdaPrev = pinSync[lcr_pkg::SYNC_SDA];
    end

    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            pinMeta <= lcr_pkg::SYNC_RST;
            pinSync <= lcr_pkg::SYNC_RST;
            sclPrev <= 1'b1;
            sdaPrev <= 1'b1;
        end else begin
            pinMeta <= next_pinMeta;
            pinSync <= next_pinSync;
            sclPrev <= next_sclPrev;
            sdaPrev <= next_sdaPrev;
        end
    end

    assign sclBit    = pinSync[lcr_pkg::SYNC_SCL];
    assign sdaBit    = pinSync[lcr_pkg::SYNC_SDA];
    assign sclRise   = sclBit & ~sclPrev;
    assign sclFall   = ~sclBit & sclPrev;
    assign startSeen = sclBit & sclPrev & sdaPrev & ~sdaBit;
    assign stopSeen  = sclBit & sclPrev & ~sdaPrev & sdaBit;

    // Reserved positions read as zero because they are never stored.
    always_comb begin
        case (pointer)
            lcr_pkg::OFS_EQ:        readData = regs.eq;
            lcr_pkg::OFS_SWING:     readData = regs.swing;
            lcr_pkg::OFS_DEEMPH:    readData = regs.deemph;
            lcr_pkg::OFS_IDLE_THR:  readData = regs.idleThr;
            lcr_pkg::OFS_IDLE_RATE: readData = regs.idleRate;
            default:                readData = lcr_pkg::RD_UNMAPPED;
        endcase
    end

    always_comb begin
        next_state    = state;
        next_bitCnt   = bitCnt;
        next_shiftReg = shiftReg;
        next_readMode = readMode;
        next_pointer  = pointer;
        next_sdaOe    = sdaOe;
        next_regs     = regs;
        if (startSeen) begin
            next_state  = lcr_pkg::ST_ADDR;
            next_bitCnt = '0;
            next_sdaOe  = 1'b0;
        end else if (stopSeen) begin
            next_state = lcr_pkg::ST_IDLE;
            next_sdaOe = 1'b0;
        end else begin
            case (state)
                lcr_pkg::ST_ADDR, lcr_pkg::ST_CMD, lcr_pkg::ST_WDATA: begin
                    if (sclRise && bitCnt != lcr_pkg::BYTE_BITS) begin
                        next_shiftReg = {shiftReg[6:0], sdaBit};
                        next_bitCnt   = bitCnt + 4'h1;
                    end else if (sclFall && bitCnt == lcr_pkg::BYTE_BITS) begin
                        next_bitCnt = '0;
                        next_sdaOe  = 1'b1;
                        if (state == lcr_pkg::ST_ADDR) begin
                            if (shiftReg[7:1] == SLAVE_ADDR) begin
                                next_readMode = shiftReg[0];
                                next_state    = lcr_pkg::ST_ADDR_ACK;
                            end else begin
                                next_sdaOe = 1'b0;
                                next_state = lcr_pkg::ST_IDLE;
                            end
                        end else if (state == lcr_pkg::ST_CMD) begin
                            next_pointer = shiftReg;
                            next_state   = lcr_pkg::ST_CMD_ACK;
                        end else begin
                            next_state = lcr_pkg::ST_WDATA_ACK;
                            // R1 R4 R5 R7 - only the field bits are stored.
                            case (pointer)
                                lcr_pkg::OFS_EQ:
                                    next_regs.eq = shiftReg & lcr_pkg::MASK_EQ;
                                lcr_pkg::OFS_SWING:
                                    next_regs.swing = shiftReg & lcr_pkg::MASK_SWING;
                                lcr_pkg::OFS_DEEMPH:
                                    next_regs.deemph = shiftReg & lcr_pkg::MASK_DEEMPH;
                                lcr_pkg::OFS_IDLE_THR:
                                    next_regs.idleThr = shiftReg & lcr_pkg::MASK_IDLE_THR;
                                lcr_pkg::OFS_IDLE_RATE:
                                    next_regs.idleRate = shiftReg & lcr_pkg::MASK_IDLE_RATE;
                                default:
                                    next_regs = regs;
                            endcase
                        end
                    end
                end
                lcr_pkg::ST_ADDR_ACK: begin
                    if (sclFall) begin
                        if (readMode) begin
                            next_shiftReg = readData;
                            next_sdaOe    = ~readData[7];
                            next_bitCnt   = lcr_pkg::BIT_FIRST;
                            next_state    = lcr_pkg::ST_RDATA;
                        end else begin
                            next_sdaOe = 1'b0;
                            next_state = lcr_pkg::ST_CMD;
                        end
                    end
                end
                lcr_pkg::ST_CMD_ACK, lcr_pkg::ST_WDATA_ACK: begin
                    if (sclFall) begin
                        next_sdaOe = 1'b0;
                        next_state = lcr_pkg::ST_WDATA;
                    end
                end
                lcr_pkg::ST_RDATA: begin
                    if (sclFall) begin
                        if (bitCnt == lcr_pkg::BYTE_BITS) begin
                            next_sdaOe = 1'b0;
                            next_state = lcr_pkg::ST_RDATA_ACK;
                        end else begin
                            next_shiftReg = {shiftReg[6:0], 1'b0};
                            next_sdaOe    = ~shiftReg[6];
                            next_bitCnt   = bitCnt + 4'h1;
                        end
                    end
                end
                lcr_pkg::ST_RDATA_ACK: begin
                    // A not-acknowledge ends the read; an acknowledge resends the register.
                    if (sclRise && sdaBit) begin
                        next_state = lcr_pkg::ST_IDLE;
                    end else if (sclFall) begin
                        next_shiftReg = readData;
                        next_sdaOe    = ~readData[7];
                        next_bitCnt   = lcr_pkg::BIT_FIRST;
                        next_state    = lcr_pkg::ST_RDATA;
                    end
                end
                lcr_pkg::ST_IDLE: begin
                    next_sdaOe = 1'b0;
                end
                default: begin
                    next_sdaOe = 1'b0;
                    next_state = lcr_pkg::ST_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            state     <= lcr_pkg::ST_IDLE;
            bitCnt    <= '0;
            shiftReg  <= '0;
            readMode  <= 1'b0;
            pointer   <= '0;
            sdaOe     <= 1'b0;
            // R2 - equalizer resets to bypass.
            regs.eq   <= lcr_pkg::RST_EQ;
            // R4 - swing resets to 600 mV.
            regs.swing    <= lcr_pkg::RST_SWING;
            regs.deemph   <= lcr_pkg::RST_DEEMPH;
            // R8 - thresholds reset to 110/70 mV.
            regs.idleThr  <= lcr_pkg::RST_IDLE_THR;
            regs.idleRate <= lcr_pkg::RST_IDLE_RATE;
        end else begin
            state    <= next_state;
            bitCnt   <= next_bitCnt;
            shiftReg <= next_shiftReg;
            readMode <= next_readMode;
            pointer  <= next_pointer;
            sdaOe    <= next_sdaOe;
            regs     <= next_regs;
        end
    end

    // The data line is only ever pulled low, so its output level stays zero.
    always_ff @(posedge mclk) begin
        smbDataOut <= 1'b0;
    end

    assign smbDataOe = sdaOe;

    // R3 R9 R10 R11 - settings and mode selection.
    lcr_lane_decode u_decode (
        .mclk             (mclk),
        .rst_n            (rst_n),
        .regs             (regs),
        .eqPinHigh        (pinSync[lcr_pkg::SYNC_EQH_MSB:lcr_pkg::SYNC_EQH_LSB]),
        .eqPinLow         (pinSync[lcr_pkg::SYNC_EQL_MSB:lcr_pkg::SYNC_EQL_LSB]),
        .idleDetected     (pinSync[lcr_pkg::SYNC_IDLE]),
        .rateDetectedGen2 (pinSync[lcr_pkg::SYNC_RATE]),
        .cond             (cond)
    );

endmodule : lcr_lane_regs

`default_nettype wire

/* File: verif/lcr_lane_regs_props.sv */
`timescale 1ns/10ps
`default_nettype none

module lcr_lane_regs_props (
    // Clock and reset.
    input wire logic               mclk,
    input wire logic               rst_n,
    // Watched pins and settings.
    input wire logic [1:0]         equalizerPinHigh,
    input wire logic [1:0]         equalizerPinLow,
    input wire logic               idleDetect,
    input wire lcr_pkg::lcr_cond_s cond
);
    default clocking @(posedge mclk); endclocking
    default disable iff (!rst_n);
    property p_rst;
        $rose(rst_n) |=> cond.eqEnable && cond.gainStage == 2'h0 && cond.boostLevel == 3'h0;
    endproperty
    a_rst: assert property (p_rst) else $error("equalizer not bypass after reset");
    property p_sw600;
        cond.swingCode == 7'h03 |-> cond.swingMv == 11'd600;
    endproperty
    a_sw600: assert property (p_sw600) else $error("swing 03 not 600 mV");
    property p_sw1400;
        cond.swingCode == 7'h3F |-> cond.swingMv == 11'd1400;
    endproperty
    a_sw1400: assert property (p_sw1400) else $error("swing 3F not 1400 mV");
    property p_pin11;
        (equalizerPinHigh == 2'h1 && equalizerPinLow == 2'h1) [*4] |-> cond.pinEqCode == 6'h2A;
    endproperty
    a_pin11: assert property (p_pin11) else $error("pin pair 11 not 2A");
    property p_pin1F;
        (equalizerPinHigh == 2'h1 && equalizerPinLow == 2'h2) [*4] |-> cond.pinEqCode == 6'h3D;
    endproperty
    a_pin1F: assert property (p_pin1F) else $error("pin pair 1F not 3D");
    property p_dem;
        cond.deemphEnhanced |-> cond.deemphLevel != 7'h40;
    endproperty
    a_dem: assert property (p_dem) else $error("reserved de-emphasis applied");
    property p_thr;
        $past(rst_n) |-> cond.deassertMv inside {8'd110, 8'd150, 8'd170, 8'd190};
    endproperty
    a_thr: assert property (p_thr) else $error("bad de-assert threshold");
    property p_mute;
        cond.signalDetectEnable |-> cond.outputMute == $past(idleDetect, 3);
    endproperty
    a_mute: assert property (p_mute) else $error("mute not following idle detect");
    c_mute: cover property (cond.outputMute);
    c_enh: cover property (cond.deemphEnhanced);
    c_pin: cover property (cond.pinEqCode == 6'h3D);
endmodule : lcr_lane_regs_props

bind lcr_lane_regs lcr_lane_regs_props u_props (.mclk(mclk), .rst_n(rst_n),
    .equalizerPinHigh(equalizerPinHigh), .equalizerPinLow(equalizerPinLow),
    .idleDetect(idleDetect), .cond(cond));

`default_nettype wire

/* File: verif/lcr_lane_regs_tb.sv */
`timescale 1ns/10ps
`default_nettype none

module lcr_lane_regs_tb;
    logic mclk = 1'b0;
    logic rst_n = 1'b0;
    logic idleDet = 1'b0;
    logic rateDet = 1'b0;
    logic [1:0] pinHi = 2'h2;
    logic [1:0] pinLo = 2'h2;
    logic smbClk, hostOe, dutOe, dOut;
    wire logic sda = !(hostOe || dutOe);
    lcr_pkg::lcr_cond_s cond;
    logic [7:0] rdat;
    logic [2:0] acks;
    logic [7:0] ofs [6] = '{8'h2C, 8'h2D, 8'h2E, 8'h2F, 8'h32, 8'h30};
    int miscompares = 0;
    int tests_run = 0;
    always #50 mclk = ~mclk;
    lcr_lane_regs DUT (.mclk(mclk), .rst_n(rst_n), .smbClk(smbClk), .smbDataIn(sda),
        .smbDataOut(dOut), .smbDataOe(dutOe), .equalizerPinHigh(pinHi), .equalizerPinLow(pinLo),
        .idleDetect(idleDet), .rateDetect(rateDet), .cond(cond));
    lcr_smb_host host (.smbClk(smbClk), .sdaOe(hostOe), .sdaIn(sda));
    task automatic chk(input logic [15:0] seen, exp);
        tests_run++;
        if (seen !== exp) begin
            miscompares++;
            $display("unexpected at %0t: %h vs %h", $time, seen, exp);
        end
    endtask : chk
    task automatic acc(input logic [7:0] o, d, input logic rd);
        host.xfer(7'h2A, o, d, rd, rdat, acks);
    endtask : acc
    task automatic settle;
        repeat (4) @(posedge mclk);
        #1;
    endtask : settle
    task automatic conclude;
        if (miscompares == 0 && tests_run > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask : conclude
    task automatic t_reset;
        logic [7:0] exp [6] = '{8'h20, 8'h03, 8'h03, 8'h00, 8'h00, 8'h00};
        host.xfer(7'h15, 8'h2C, 8'h00, 1'b0, rdat, acks);
        chk({dOut, acks}, 16'h7);
        for (int i = 0; i < 6; i++) begin
            acc(ofs[i], 8'h00, 1'b1);
            chk(rdat, exp[i]);
        end
    endtask : t_reset
    task automatic t_fields;
        logic [7:0] val [5] = '{8'h3B, 8'h3F, 8'hA0, 8'h0E, 8'h22};
        for (int i = 0; i < 5; i++) begin
            acc(ofs[i], val[i], 1'b0);
            acc(ofs[i], 8'h00, 1'b1);
            chk(rdat, val[i]);
        end
        chk({cond.eqEnable, cond.gainStage, cond.boostLevel}, 16'h3B);
        chk(cond.swingMv, 16'd1400);
        chk({cond.deemphEnhanced, cond.deemphLevel}, 16'hA0);
        chk({cond.deassertMv, cond.assertMv}, {8'd190, 8'd130});
        idleDet = 1'b1;
        rateDet = 1'b1;
        settle;
        chk({cond.outputMute, cond.signalDetectEnable, cond.rateGen2}, 16'h7);
        idleDet = 1'b0;
        rateDet = 1'b0;
        acc(8'h32, 8'h11, 1'b0);
        chk({cond.outputMute, cond.signalDetectEnable, cond.rateGen2}, 16'h5);
        acc(8'h32, 8'h00, 1'b0);
        chk({cond.outputMute, cond.signalDetectEnable, cond.rateGen2}, 16'h0);
    endtask : t_fields
    task automatic t_deemph;
        logic [7:0] code [5] = '{8'h01, 8'h88, 8'h90, 8'hA0, 8'hC0};
        logic [7:0] exp [5] = '{8'h01, 8'h88, 8'h90, 8'hA0, 8'h01};
        for (int i = 0; i < 5; i++) begin
            acc(8'h2E, code[i], 1'b0);
            chk({cond.deemphEnhanced, cond.deemphLevel}, exp[i]);
        end
    endtask : t_deemph
    task automatic t_pins;
        logic [3:0] pin [9] = '{4'h5, 4'h0, 4'h8, 4'h4, 4'h9, 4'h1, 4'h2, 4'h6, 4'hA};
        logic [5:0] exp [9] = '{6'h2A, 6'h30, 6'h32, 6'h39, 6'h35, 6'h35, 6'h3B, 6'h3D, 6'h20};
        for (int i = 0; i < 9; i++) begin
            {pinHi, pinLo} = pin[i];
            settle;
            chk(cond.pinEqCode, exp[i]);
        end
    endtask : t_pins
    initial begin
        repeat (10) @(posedge mclk);
        #1 rst_n = 1'b1;
        settle;
        t_reset;
        t_fields;
        t_deemph;
        t_pins;
        conclude;
    end
endmodule : lcr_lane_regs_tb

`default_nettype wire

/* File: verif/lcr_smb_host.sv */
`timescale 1ns/10ps
`default_nettype none

module lcr_smb_host (
    // Bus pins; the data line has a pull-up.
    output var logic smbClk,
    output var logic sdaOe,
    input wire logic sdaIn
);
    initial begin
        smbClk = 1'b1;
        sdaOe = 1'b0;
    end
    // Data only moves while the clock is low, phases of 500 ns.
    task automatic bitX(input logic b, output logic r);
        sdaOe = !b;
        #500 smbClk = 1'b1;
        r = sdaIn;
        #500 smbClk = 1'b0;
    endtask : bitX
    task automatic byteX(input logic [7:0] d, output logic [7:0] r, output logic ack);
        for (int i = 7; i >= 0; i--) bitX(d[i], r[i]);
        bitX(1'b1, ack);
    endtask : byteX
    task automatic edgeS(input logic stop);
        sdaOe = stop;
        #500 smbClk = 1'b1;
        #500 sdaOe = !stop;
        #500 smbClk = stop;
    endtask : edgeS
    task automatic xfer(input logic [6:0] a, input logic [7:0] ofs, d, input logic rd,
                        output logic [7:0] r, output logic [2:0] acks);
        logic [7:0] junk;
        edgeS(1'b0);
        byteX({a, 1'b0}, junk, acks[2]);
        byteX(ofs, junk, acks[1]);
        if (rd) begin
            edgeS(1'b0);
            byteX({a, 1'b1}, junk, acks[0]);
            byteX(8'hFF, r, junk[0]);
        end else begin
            byteX(d, junk, acks[0]);
        end
        edgeS(1'b1);
    endtask : xfer
endmodule : lcr_smb_host

`default_nettype wire
